// *** design/cbg_pkg.sv ***
// cbg_pkg: register map, field layouts and timing constants for the
// console serial controller and its bit-rate down-counter.
// assumes a 100 MHz system clock and 16-bit word-addressed register access.

package cbg_pkg;

  // ----------------------------------------------------------------
  // register word addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_LINE_CONTROL = 16'hFC10;
  localparam logic [15:0] ADDR_FORMAT_CONTROL = 16'hFC11;
  localparam logic [15:0] ADDR_LINE_STATUS = 16'hFC12;
  localparam logic [15:0] ADDR_HOLDING = 16'hFC13;
  localparam logic [15:0] ADDR_DIVIDER_COUNT = 16'hFC20;
  localparam logic [15:0] ADDR_COUNTER_MODE = 16'hFC23;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  // all active-low enables off: receiver, transmitter, parity disabled
  localparam logic [7:0] LINE_CONTROL_RESET = 8'hFF;
  // eight bits, async, odd parity, counter clock select
  localparam logic [7:0] FORMAT_CONTROL_RESET = 8'hE6;
  localparam logic [7:0] HOLDING_RESET = 8'h00;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CLK_SEL_COUNTER = 3'b110;
  localparam logic [1:0] CNT_SEL_BAUD = 2'b00;
  localparam logic [1:0] CNT_SEL_ILLEGAL = 2'b11;
  localparam logic [1:0] LOAD_LOW = 2'b01;
  localparam logic [1:0] LOAD_HIGH = 2'b10;
  localparam logic [1:0] LOAD_LOW_HIGH = 2'b11;
  localparam logic [2:0] MODE_RATE_GEN = 3'b010;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int COUNT_CLK_HZ = 1_250_000;
  localparam int COUNT_CLK_DIV = SYS_CLK_HZ / COUNT_CLK_HZ;
  // counter ticks per bit: 1.25 MHz / 39066 per bit/s
  localparam int OVERSAMPLE = 32;
  localparam logic [5:0] TICKS_PER_BIT = 6'd32;
  localparam logic [5:0] TICKS_HALF_BIT = 6'd16;

  // ----------------------------------------------------------------
  // packed layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic loopBack;
    logic line_spacing_hold;
    logic twoStop;
    logic echoLow;
    logic parity_active_low;
    logic rx_gate_low;
    logic rtsCtrl;
    logic dtrCtrl;
  } cbg_line_ctrl_t;

  typedef struct packed {
    logic [1:0] charLen;
    logic asyncMode;
    logic evenParity;
    logic altRxClk;
    logic [2:0] clkSel;
  } cbg_format_t;

  typedef struct packed {
    logic [1:0] cntSel;
    logic [1:0] loadMethod;
    logic [2:0] cntMode;
    logic bcdCount;
  } cbg_mode_t;

endpackage : cbg_pkg

// *** design/cbg_prescaler.sv ***
// cbg_prescaler: one-cycle strobe at the counter input clock rate.
// assumes clk_sys is the 100 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

module cbg_prescaler #(
  parameter int DIV = cbg_pkg::COUNT_CLK_DIV
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // strobe out
  output logic strobe
);
  import cbg_pkg::*;

  logic [7:0] div_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign strobe = (div_q == 8'(DIV - 1));

endmodule : cbg_prescaler

`default_nettype wire

// *** design/cbg_baud_counter.sv ***
// cbg_baud_counter: programmable down-counter producing the bit-rate tick.
// assumes countEn is a one-cycle strobe at the counter input rate.
`timescale 1ns/1ps
`default_nettype none

module cbg_baud_counter (
  // clock, reset and count strobe
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic countEn,
  // register writes
  input wire logic modeWr,
  input wire logic [7:0] modeByte,
  input wire logic cntWr,
  input wire logic [7:0] cntByte,
  // outputs
  output logic [7:0] readByte,
  output logic tick
);
  import cbg_pkg::*;

  cbg_mode_t mode_q;
  logic [15:0] reload_q;
  logic [15:0] count_q;
  logic highNext_q;
  logic running_q;
  cbg_mode_t newMode;

  assign newMode = cbg_mode_t'(modeByte);
  assign tick = running_q && countEn && (count_q == 16'h0001);
  assign readByte = (mode_q.loadMethod == LOAD_HIGH) ? count_q[15:8]
                                                     : count_q[7:0];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_q <= cbg_mode_t'(8'h00);
      reload_q <= DIVIDER_RESET;
      count_q <= DIVIDER_RESET;
      highNext_q <= 1'b0;
      running_q <= 1'b0;
    end else if (modeWr) begin
      // other counters of the timer are not here; illegal select ignored
      if (newMode.cntSel == CNT_SEL_BAUD) begin // [R19] [R24]
        mode_q <= newMode;
        highNext_q <= 1'b0;
        running_q <= 1'b0;
      end
    end else if (cntWr) begin
      unique case (mode_q.loadMethod) // [R20]
        LOAD_LOW: begin
          reload_q[7:0] <= cntByte;
          count_q <= {reload_q[15:8], cntByte};
          running_q <= 1'b1; // [R21]
        end
        LOAD_HIGH: begin
          reload_q[15:8] <= cntByte;
          count_q <= {cntByte, reload_q[7:0]};
          running_q <= 1'b1; // [R21]
        end
        LOAD_LOW_HIGH: begin
          if (!highNext_q) begin
            reload_q[7:0] <= cntByte;
            highNext_q <= 1'b1;
            running_q <= 1'b0;
          end else begin
            reload_q[15:8] <= cntByte;
            count_q <= {cntByte, reload_q[7:0]};
            highNext_q <= 1'b0;
            running_q <= 1'b1; // [R21]
          end
        end
        default: begin
        end
      endcase
    end else if (running_q && countEn) begin // [R16]
      if (count_q == 16'h0001) begin
        count_q <= reload_q;
        // rate-generator mode restarts; any other mode stops at zero
        running_q <= (mode_q.cntMode == MODE_RATE_GEN); // [R18]
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

endmodule : cbg_baud_counter

`default_nettype wire

// *** design/cbg_console_uart.sv ***
// cbg_console_uart: console serial controller with its bit-rate counter.
// assumes register strobes are single-cycle and synchronous to clk_sys,
// and that the serial and modem pins are already synchronous.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: word or byte access; only low byte meaningful; high byte undefined.
// R2: loopback 1 feeds transmitter to receiver and masks ring events.
// R3: spacing hold 0 with transmitter on holds line spacing from next char.
// R4: stop select 0 gives one stop; 1 gives two, or 1.5 for 5 bits.
// R5: echo 0 with receiver on copies receive line to transmit output.
// R6: parity enable is active low: generate and check parity at 0.
// R7: receive gate 0 runs receiver; 1 clears status bits 1-4 and stops.
// R8: transmit only with request bit 0 and clear-to-send; drop after char.
// R9: terminal-ready 0 enables carrier, set-ready, ring; 1 ring only.
// R10: length codes 00..11 give 5, 6, 7 or 8 data bits.
// R11: mode bit 1 selects async; software always writes 1.
// R12: parity sense 0 is odd parity, 1 is even parity.
// R13: software keeps alternate receive clock bit at 0.
// R14: clock select 110 takes both bit clocks from the rate counter.
// R15: full duplex from 50 to 19,200 bits per second.
// R16: rate counter decrements at 1.25 MHz, ticks when reaching zero.
// R17: software loads counter with 39066 / rate, rounded.
// R18: rate counter in mode 010 reloads and restarts at zero.
// R19: mode write counter select 00, 01, 10 picks counter; 11 illegal.
// R20: load method 01 low, 10 high, 11 low then high byte.
// R21: mode written first; counting starts right after the final load.
// R22: boot firmware sets console rate from a three-bit switch field.
// R23: holding registers carry the ones-complement of the line data.
// R24: mode write with counter select 11 is ignored.
module cbg_console_uart (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register access
  input wire logic [15:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  // serial line
  input wire logic serialRxd,
  output logic serialTxd,
  // modem control
  input wire logic ctsActive,
  input wire logic dsrActive,
  input wire logic carrierActive,
  input wire logic ringActive,
  output logic rtsActive,
  output logic dtrActive,
  output logic dataSetEvent
);
  import cbg_pkg::*;

  // ----------------------------------------------------------------
  // types and declarations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } cbg_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } cbg_rx_state_t;

  cbg_line_ctrl_t lineCtrl_q;
  cbg_format_t format_q;
  cbg_tx_state_t txState_q;
  cbg_rx_state_t rxState_q;
  logic [7:0] txHolding_q;
  logic txHoldFull_q;
  logic threBit_q;
  logic [7:0] txShift_q;
  logic [5:0] txCnt_q;
  logic [2:0] txBit_q;
  logic [2:0] txStopHalves_q;
  logic txLine_q;
  logic txSpacing_q;
  logic [7:0] rxShift_q;
  logic [5:0] rxCnt_q;
  logic [2:0] rxBit_q;
  logic rxParity_q;
  logic [7:0] rxHolding_q;
  logic drFull_q;
  logic feErr_q;
  logic peErr_q;
  logic oeErr_q;
  logic dscEvt_q;
  logic [2:0] modemPrev_q;
  logic [15:0] regRdData_q;
  logic serialTxd_q;

  logic countStrobe;
  logic rateTick;
  logic bitTick;
  logic txEnable;
  logic rxEnable;
  logic parityOn;
  logic [2:0] lastBit;
  logic rxLine;
  logic wrHolding;
  logic rdHolding;
  logic rdStatus;
  logic [7:0] statusByte;
  logic [7:0] counterByte;
  logic rxDone;
  logic rxFrameBad;
  logic rxParityBad;
  logic modemChange;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic regHit(input logic [15:0] addr,
                                  input logic [15:0] offset);
    regHit = (addr == offset);
  endfunction : regHit

  function automatic logic [7:0] lenMask(input logic [1:0] len);
    lenMask = 8'hFF >> (2'd3 - len); // [R10]
  endfunction : lenMask

  function automatic logic parityOf(input logic [7:0] data,
                                    input logic [1:0] len,
                                    input logic even);
    // odd sense makes total ones odd, even sense makes it even
    parityOf = (^(data & lenMask(len))) ^ ~even; // [R12]
  endfunction : parityOf

  // ----------------------------------------------------------------
  // timing chain
  // ----------------------------------------------------------------
  cbg_prescaler #(
    .DIV(COUNT_CLK_DIV)
  ) uPrescaler (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .strobe(countStrobe)
  );

  cbg_baud_counter uBaudCounter (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .countEn(countStrobe), // [R16]
    .modeWr(regWrite && regHit(regAddr, ADDR_COUNTER_MODE)),
    .modeByte(regWrData[7:0]),
    .cntWr(regWrite && regHit(regAddr, ADDR_DIVIDER_COUNT)),
    .cntByte(regWrData[7:0]),
    .readByte(counterByte),
    .tick(rateTick)
  );

  // other clock selects have no source here, so the engines stall
  assign bitTick = rateTick && (format_q.clkSel == CLK_SEL_COUNTER); // [R14]

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  assign wrHolding = regWrite && regHit(regAddr, ADDR_HOLDING);
  assign rdHolding = regRead && regHit(regAddr, ADDR_HOLDING);
  assign rdStatus = regRead && regHit(regAddr, ADDR_LINE_STATUS);

  // status is active low except the raw modem levels
  assign statusByte = {~dscEvt_q, dsrActive, carrierActive, ~feErr_q,
                       ~peErr_q, ~oeErr_q, ~drFull_q, threBit_q};

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lineCtrl_q <= cbg_line_ctrl_t'(LINE_CONTROL_RESET);
      format_q <= cbg_format_t'(FORMAT_CONTROL_RESET);
    end else if (regWrite) begin
      // only the low byte is stored, word or byte access alike
      if (regHit(regAddr, ADDR_LINE_CONTROL)) begin // [R1]
        lineCtrl_q <= cbg_line_ctrl_t'(regWrData[7:0]);
      end
      if (regHit(regAddr, ADDR_FORMAT_CONTROL)) begin // [R1]
        format_q <= cbg_format_t'(regWrData[7:0]); // [R11] [R13]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      regRdData_q <= 16'h0000;
    end else if (regRead) begin
      // high byte read as zero; unmapped words read zero
      unique case (regAddr) // [R1]
        ADDR_LINE_CONTROL: regRdData_q <= {8'h00, lineCtrl_q};
        ADDR_FORMAT_CONTROL: regRdData_q <= {8'h00, format_q};
        ADDR_LINE_STATUS: regRdData_q <= {8'h00, statusByte};
        ADDR_HOLDING: regRdData_q <= {8'h00, rxHolding_q};
        ADDR_DIVIDER_COUNT: regRdData_q <= {8'h00, counterByte};
        default: regRdData_q <= 16'h0000;
      endcase
    end
  end

  assign regRdData = regRdData_q;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  assign txEnable = !lineCtrl_q.rtsCtrl && ctsActive; // [R8]
  assign parityOn = !lineCtrl_q.parity_active_low; // [R6]
  assign lastBit = 3'd4 + {1'b0, format_q.charLen}; // [R10]

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      txHolding_q <= HOLDING_RESET;
      txHoldFull_q <= 1'b0;
      threBit_q <= 1'b1;
    end else begin
      if (wrHolding) begin
        txHolding_q <= regWrData[7:0];
        txHoldFull_q <= 1'b1;
        threBit_q <= 1'b1;
      end else if (txState_q == TX_IDLE && txEnable && txHoldFull_q) begin
        txHoldFull_q <= 1'b0;
        threBit_q <= 1'b0;
      end else if (!txEnable) begin
        threBit_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      txState_q <= TX_IDLE;
      txShift_q <= 8'h00;
      txCnt_q <= 6'd0;
      txBit_q <= 3'd0;
      txStopHalves_q <= 3'd0;
      txLine_q <= 1'b1;
      txSpacing_q <= 1'b0;
    end else begin
      unique case (txState_q)
        TX_IDLE: begin
          txLine_q <= 1'b1;
          // a character already on the line finishes before a stop
          if (txEnable && txHoldFull_q && !wrHolding) begin // [R8]
            txShift_q <= ~txHolding_q & lenMask(format_q.charLen); // [R23]
            txSpacing_q <= !lineCtrl_q.line_spacing_hold; // [R3]
            txStopHalves_q <= !lineCtrl_q.twoStop ? 3'd2 : // [R4]
                              (format_q.charLen == 2'b00) ? 3'd3 : 3'd4;
            txCnt_q <= 6'd0;
            txBit_q <= 3'd0;
            txState_q <= TX_START;
          end
        end
        TX_START: begin
          txLine_q <= 1'b0;
          if (bitTick) begin
            if (txCnt_q == TICKS_PER_BIT - 6'd1) begin
              txCnt_q <= 6'd0;
              txState_q <= TX_DATA;
            end else begin
              txCnt_q <= txCnt_q + 6'd1;
            end
          end
        end
        TX_DATA: begin
          txLine_q <= txShift_q[txBit_q];
          if (bitTick) begin
            if (txCnt_q == TICKS_PER_BIT - 6'd1) begin
              txCnt_q <= 6'd0;
              txBit_q <= txBit_q + 3'd1;
              if (txBit_q == lastBit) begin
                txState_q <= parityOn ? TX_PAR : TX_STOP; // [R6]
              end
            end else begin
              txCnt_q <= txCnt_q + 6'd1;
            end
          end
        end
        TX_PAR: begin
          txLine_q <= parityOf(txShift_q, format_q.charLen,
                               format_q.evenParity); // [R6] [R12]
          if (bitTick) begin
            if (txCnt_q == TICKS_PER_BIT - 6'd1) begin
              txCnt_q <= 6'd0;
              txState_q <= TX_STOP;
            end else begin
              txCnt_q <= txCnt_q + 6'd1;
            end
          end
        end
        TX_STOP: begin
          txLine_q <= 1'b1;
          if (bitTick) begin
            // stop length counted in half bits
            if (txCnt_q == TICKS_HALF_BIT - 6'd1) begin // [R4]
              txCnt_q <= 6'd0;
              txStopHalves_q <= txStopHalves_q - 3'd1;
              if (txStopHalves_q == 3'd1) begin
                txState_q <= TX_IDLE;
              end
            end else begin
              txCnt_q <= txCnt_q + 6'd1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // line output and modem pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      serialTxd_q <= 1'b1;
    end else if (lineCtrl_q.loopBack) begin
      serialTxd_q <= 1'b1; // [R2]
    end else if (!lineCtrl_q.echoLow && !lineCtrl_q.rx_gate_low) begin
      serialTxd_q <= serialRxd; // [R5]
    end else if (txSpacing_q && txEnable && txState_q != TX_IDLE) begin
      serialTxd_q <= 1'b0; // [R3]
    end else begin
      serialTxd_q <= txLine_q;
    end
  end

  assign serialTxd = serialTxd_q;
  assign rtsActive = !lineCtrl_q.rtsCtrl || (txState_q != TX_IDLE); // [R8]
  assign dtrActive = !lineCtrl_q.dtrCtrl;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  assign rxEnable = !lineCtrl_q.rx_gate_low; // [R7]
  assign rxLine = lineCtrl_q.loopBack ? txLine_q : serialRxd; // [R2]
  assign rxDone = bitTick && rxState_q == RX_STOP
                  && rxCnt_q == TICKS_PER_BIT - 6'd1;
  assign rxFrameBad = !rxLine; // [R15]
  assign rxParityBad = parityOn && (rxParity_q != parityOf(rxShift_q,
                       format_q.charLen, format_q.evenParity)); // [R6]

  always_ff @(posedge clk_sys) begin
    if (!rst_b || !rxEnable) begin
      rxState_q <= RX_IDLE;
      rxShift_q <= 8'h00;
      rxCnt_q <= 6'd0;
      rxBit_q <= 3'd0;
      rxParity_q <= 1'b0;
    end else if (bitTick) begin
      unique case (rxState_q)
        RX_IDLE: begin
          if (!rxLine) begin
            rxCnt_q <= 6'd0;
            rxState_q <= RX_START;
          end
        end
        RX_START: begin
          // realign to mid-bit; a short glitch is not a start
          if (rxCnt_q == TICKS_HALF_BIT - 6'd1) begin
            rxCnt_q <= 6'd0;
            rxBit_q <= 3'd0;
            rxShift_q <= 8'h00;
            rxState_q <= rxLine ? RX_IDLE : RX_DATA;
          end else begin
            rxCnt_q <= rxCnt_q + 6'd1;
          end
        end
        RX_DATA: begin
          if (rxCnt_q == TICKS_PER_BIT - 6'd1) begin
            rxCnt_q <= 6'd0;
            rxShift_q[rxBit_q] <= rxLine;
            rxBit_q <= rxBit_q + 3'd1;
            if (rxBit_q == lastBit) begin // [R10]
              rxState_q <= parityOn ? RX_PAR : RX_STOP;
            end
          end else begin
            rxCnt_q <= rxCnt_q + 6'd1;
          end
        end
        RX_PAR: begin
          if (rxCnt_q == TICKS_PER_BIT - 6'd1) begin
            rxCnt_q <= 6'd0;
            rxParity_q <= rxLine;
            rxState_q <= RX_STOP;
          end else begin
            rxCnt_q <= rxCnt_q + 6'd1;
          end
        end
        RX_STOP: begin
          if (rxCnt_q == TICKS_PER_BIT - 6'd1) begin
            rxCnt_q <= 6'd0;
            rxState_q <= RX_IDLE;
          end else begin
            rxCnt_q <= rxCnt_q + 6'd1;
          end
        end
      endcase
    end
  end

  // receive status; a new character beats a same-cycle read
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !rxEnable) begin
      // a receiver disable clears status only; held data survives it
      rxHolding_q <= rst_b ? rxHolding_q : HOLDING_RESET;
      drFull_q <= 1'b0; // [R7]
      feErr_q <= 1'b0;
      peErr_q <= 1'b0;
      oeErr_q <= 1'b0;
    end else if (rxDone) begin
      if (drFull_q && !rdHolding) begin
        oeErr_q <= 1'b1;
      end else begin
        rxHolding_q <= ~(rxShift_q & lenMask(format_q.charLen)); // [R23]
        drFull_q <= 1'b1;
        feErr_q <= rxFrameBad;
        peErr_q <= rxParityBad; // [R6]
      end
    end else if (rdHolding) begin
      drFull_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // data set change
  // ----------------------------------------------------------------
  assign modemChange =
      (!lineCtrl_q.dtrCtrl && (modemPrev_q[2] != dsrActive
                               || modemPrev_q[1] != carrierActive)) // [R9]
      || (!lineCtrl_q.loopBack && modemPrev_q[0] != ringActive); // [R2]

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      modemPrev_q <= {dsrActive, carrierActive, ringActive};
      dscEvt_q <= 1'b0;
    end else begin
      modemPrev_q <= {dsrActive, carrierActive, ringActive};
      if (modemChange) begin
        dscEvt_q <= 1'b1;
      end else if (rdStatus) begin
        dscEvt_q <= 1'b0;
      end
    end
  end

  assign dataSetEvent = dscEvt_q;

endmodule : cbg_console_uart

`default_nettype wire

// *** test/cbg_uart_props.sv ***
// cbg_uart_props: port checks for the console controller.
// assumes binding to cbg_console_uart, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cbg_uart_props
  import cbg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register access
  input wire logic [15:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  // line and modem
  input wire logic serialTxd,
  input wire logic dsrActive,
  input wire logic ringActive,
  input wire logic rtsActive,
  input wire logic dtrActive,
  input wire logic dataSetEvent
);
  logic [7:0] lineCtrl_q;
  default clocking cbgClk @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // shadow of line control, rebuilt from write strobes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lineCtrl_q <= 8'hFF;
    end else if (regWrite && regAddr == ADDR_LINE_CONTROL) begin
      lineCtrl_q <= regWrData[7:0];
    end
  end
  sequence s_lc_wr;
    regWrite && regAddr == ADDR_LINE_CONTROL;
  endsequence
  sequence s_rd(logic [15:0] a);
    regRead && regAddr == a;
  endsequence
  property p_hi_zero; regRead |=> regRdData[15:8] == 8'h00; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high byte");
  property p_dtr; s_lc_wr |=> dtrActive == !lineCtrl_q[0]; endproperty
  a_dtr: assert property (p_dtr) else $error("dtr level");
  property p_rts; s_lc_wr ##0 !regWrData[1] |=> rtsActive; endproperty
  a_rts: assert property (p_rts) else $error("rts off");
  property p_mode_rd;
    s_rd(ADDR_COUNTER_MODE) |=> regRdData == 16'h0000;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read");
  property p_loop; (lineCtrl_q[7] && lineCtrl_q[4]) [*2] |-> serialTxd;
  endproperty
  a_loop: assert property (p_loop) else $error("loop line");
  property p_ds_set;
    dsrActive != $past(dsrActive) && !lineCtrl_q[0] |-> ##[1:3] dataSetEvent;
  endproperty
  a_ds_set: assert property (p_ds_set) else $error("no event");
  property p_ds_clr;
    s_rd(ADDR_LINE_STATUS) ##0 $stable(dsrActive) ##0 $stable(ringActive)
      |-> ##[1:2] !dataSetEvent;
  endproperty
  a_ds_clr: assert property (p_ds_clr) else $error("event kept");
  property p_ring_loop;
    ringActive != $past(ringActive) && lineCtrl_q[7] && !dataSetEvent
      |=> !dataSetEvent [*3];
  endproperty
  a_ring_loop: assert property (p_ring_loop) else $error("ring");
endmodule : cbg_uart_props
`default_nettype wire

// *** test/cbg_term_model.sv ***
// cbg_term_model: console terminal on the far side of the line.
// assumes mark idle and a bit period counted in clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module cbg_term_model #(
  parameter int BIT = 2560
) (
  // clock and line
  input wire logic clk_sys,
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'b1; // idle mark
  // start bit, then bits lsb first; caller supplies stop bits
  task automatic send(input logic [15:0] bits, input int n);
    lineOut <= 1'b0;
    repeat (BIT) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      lineOut <= bits[i];
      repeat (BIT) @(posedge clk_sys);
    end
    lineOut <= 1'b1;
  endtask : send
  // mid-bit sampling, independent of the far clock phase
  task automatic recv(input int n, output logic [15:0] bits);
    bits = 16'h0000;
    @(negedge lineIn);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk_sys);
      bits[i] = lineIn;
    end
  endtask : recv
endmodule : cbg_term_model
`default_nettype wire

// *** test/cbg_console_uart_tb.sv ***
// cbg_console_uart_tb: register-level tests of the console controller.
// assumes a rate reload of 1, so one bit is 2560 clocks.
`timescale 1ns/1ps
`default_nettype none
module cbg_console_uart_tb;
  import cbg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] regAddr = 16'h0000, regWrData = 16'h0000, regRdData, d;
  logic regWrite = 1'b0, regRead = 1'b0, serialRxd, serialTxd;
  logic ctsActive = 1'b1, dsrActive = 1'b0, ringActive = 1'b0;
  logic carrierActive = 1'b0, rtsActive, dtrActive, dataSetEvent;
  int nMismatch = 0;
  int checked = 0;
  always #5 clk_sys = ~clk_sys;
  cbg_console_uart u_cbg_console_uart (.*);
  cbg_term_model #(.BIT(2560)) u_cbg_term_model (.clk_sys(clk_sys),
    .lineIn(serialTxd), .lineOut(serialRxd));
  task automatic end_of_test;
    if (nMismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] a, v);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask : rd
  task automatic chk(input logic [15:0] a, exp);
    logic [15:0] v;
    rd(a, v);
    cmp(v, exp);
  endtask : chk
  // two characters at 2560 clocks a bit fit well inside this
  initial begin
    repeat (90_000) @(posedge clk_sys);
    nMismatch++;
    $display("mismatch at %0t: timeout", $time);
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk(ADDR_LINE_CONTROL, 16'h00FF);
    chk(16'hFC15, 16'h0000);
    chk(ADDR_COUNTER_MODE, 16'h0000);
    wr(ADDR_COUNTER_MODE, 16'hFF14);
    wr(ADDR_DIVIDER_COUNT, 16'h0001);
    wr(ADDR_COUNTER_MODE, 16'h00E4);
    wr(ADDR_FORMAT_CONTROL, 16'h00A6);
    chk(ADDR_FORMAT_CONTROL, 16'h00A6);
    wr(ADDR_LINE_CONTROL, 16'h0050);
    #1 cmp({14'h0000, rtsActive, dtrActive}, 16'h0003);
    fork
      u_cbg_term_model.recv(9, d);
      wr(ADDR_HOLDING, 16'h00CA);
    join
    cmp(d, 16'h01B5);
    wr(ADDR_FORMAT_CONTROL, 16'h00E6);
    wr(ADDR_LINE_CONTROL, 16'h0058);
    u_cbg_term_model.send(16'h015A, 9);
    rd(ADDR_LINE_STATUS, d);
    cmp({12'h000, d[4:1]}, 16'h000E);
    wr(ADDR_LINE_CONTROL, 16'h005C);
    rd(ADDR_LINE_STATUS, d);
    cmp({12'h000, d[4:1]}, 16'h000F);
    chk(ADDR_HOLDING, 16'h00A5);
    @(posedge clk_sys);
    dsrActive <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 cmp({15'h0000, dataSetEvent}, 16'h0001);
    rd(ADDR_LINE_STATUS, d);
    cmp({14'h0000, d[7:6]}, 16'h0001);
    wr(ADDR_LINE_CONTROL, 16'h00D7);
    ringActive <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 cmp({serialTxd, rtsActive, dtrActive, dataSetEvent}, 16'h0008);
    wr(ADDR_LINE_CONTROL, 16'h0040);
    u_cbg_term_model.lineOut <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 cmp({15'h0000, serialTxd}, 16'h0000);
    end_of_test();
  end
endmodule : cbg_console_uart_tb
bind cbg_console_uart cbg_uart_props u_cbg_uart_props (.*);
`default_nettype wire
